// *** dv/cpu_exec_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module cpu_exec_model (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic [5:0]       regAddr,
    output logic [31:0]      regWdata,
    output logic             regWrite,
    output logic             regRead,
    input  wire logic [31:0] regRdata,
    input  wire logic        regDenied,
    // Exception sequencing
    output logic             excEvent,
    output logic             intAccept,
    output logic [31:0]      excOffset,
    output logic             rteEvent
);
    int gap = 0;
    initial begin
        {regAddr, regWdata, regWrite, regRead} = '0;
        {excEvent, intAccept, excOffset, rteEvent} = '0;
    end
    // Released address and data lines show the inverse and both strobes drop to zero, so a design leaning on stale values is caught
    task automatic acc(input bit w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] v, output logic dn);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= w;
        regRead <= !w;
        @(posedge clk);
        regAddr <= ~a;
        regWdata <= ~d;
        {regWrite, regRead} <= 2'b00;
        #1;
        v = regRdata;
        dn = regDenied;
    endtask
    task automatic evt(input logic [1:0] k, input logic [31:0] off);
        @(posedge clk);
        excEvent <= k == 2'd0;
        intAccept <= k == 2'd1;
        rteEvent <= k == 2'd2;
        excOffset <= off;
        @(posedge clk);
        {excEvent, intAccept, rteEvent} <= 3'b000;
        excOffset <= ~off;
    endtask
endmodule // cpu_exec_model
`default_nettype wire

// *** dv/rf_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rf_params.svh"
module rf_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register port
    input wire logic [5:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        regDenied,
    // Exception sequencing
    input wire logic        excEvent,
    input wire logic        intAccept,
    input wire logic [31:0] excOffset,
    input wire logic        rteEvent,
    // Mode and status view
    input wire logic        privMode,
    input wire logic        bankSelect,
    input wire logic        blockBit,
    input wire logic [3:0]  interruptMaskLevel,
    input wire logic [31:0] indexValue,
    input wire logic [31:0] instructionPointer,
    input wire logic [31:0] vectorBase
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic [31:0] entryIp_reg;
    logic        acc;
    logic        noExc;
    assign acc = regRead | regWrite;
    assign noExc = !excEvent && !intAccept;
    // Captured at the event so a vector write in the same cycle cannot hide a slip
    always_ff @(posedge clk) entryIp_reg <= vectorBase + excOffset;
    reset_state_a: assert property (disable iff (1'b0) !rstn |=> privMode && bankSelect && blockBit
        && interruptMaskLevel == 4'hF && instructionPointer == `RF_IPTR_RESET && vectorBase == 32'h0)
        else $error("state after reset is wrong");
    exc_entry_a: assert property ((excEvent || intAccept) |=> privMode && bankSelect && blockBit
        && instructionPointer == entryIp_reg)
        else $error("exception entry state is wrong");
    user_bank_one_a: assert property (acc && !privMode && regAddr inside {[6'h10:6'h17]}
        |=> regDenied && regRdata == 32'h0)
        else $error("bank one reachable in user mode");
    user_ctrl_deny_a: assert property (acc && !privMode && regAddr inside {[6'h1A:6'h1C]} |=> regDenied)
        else $error("saved or vector register reachable in user mode");
    any_mode_sys_a: assert property (acc && regAddr inside {[6'h18:6'h20]} && regAddr != 6'h1A
        && (privMode || regAddr < 6'h1A || regAddr > 6'h1C) |=> !regDenied)
        else $error("open register refused");
    gen_regs_open_a: assert property (acc && (regAddr < 6'h10 || privMode && regAddr < 6'h18)
        |=> !regDenied)
        else $error("general register refused");
    status_guard_a: assert property (regWrite && !privMode && regAddr == `RF_ADDR_STATUS && noExc
        |=> !privMode && $stable(bankSelect) && $stable(blockBit) && $stable(interruptMaskLevel))
        else $error("user write changed guarded status bits");
    status_hide_a: assert property (regRead && !privMode && regAddr == `RF_ADDR_STATUS
        |=> (regRdata & `RF_STAT_PRIV_MASK) == 32'h0)
        else $error("guarded status bits visible in user mode");
    index_track_a: assert property (regWrite && regAddr == 6'h00 && noExc |=> indexValue == $past(regWdata))
        else $error("index register does not follow R0");
    cover property (excEvent ##[1:4] rteEvent);
    cover property (regRead && !privMode && regAddr == `RF_ADDR_SSTATUS);
    cover property (regWrite && regAddr == `RF_ADDR_STATUS ##[1:2] regRead);
endmodule // rf_checker
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rf_params.svh"
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
bind banked_cpu_register_file rf_checker chk (.*);
module testbench;
    localparam logic [31:0] IM = `RF_STAT_IMPL_MASK;
    localparam logic [31:0] PM = `RF_STAT_PRIV_MASK;
    logic        clk;
    logic        rstn = 1'b0;
    logic [5:0]  regAddr;
    logic [31:0] regWdata, regRdata, excOffset, indexValue, instructionPointer, vectorBase;
    logic        regWrite, regRead, regDenied, excEvent, intAccept, rteEvent;
    logic        privMode, bankSelect, blockBit;
    logic [3:0]  interruptMaskLevel;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          seed = 32'h4481BD0B;
    // Model: status, global, saved status, saved pointer, vector, mac high/low, link, pointer
    logic [31:0] sys [9];
    logic [31:0] lo [2][8];
    logic [31:0] hi [8];
    logic [31:0] modes [4] = '{32'h700000F0, 32'h400000F0, 32'h00000000, 32'h700000F3};
    banked_cpu_register_file DUT (.*);
    cpu_exec_model cpuModel (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic mAcc(input bit w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] v, output logic dn);
        logic        p;
        logic        b;
        logic [31:0] m;
        int          j;
        p = sys[0][30];
        b = p & sys[0][29];
        v = 32'h0;
        dn = a > 6'h20 || (!p && (a inside {[6'h10:6'h17], [6'h1A:6'h1C]}));
        j = int'(a) - 24;
        if (a < 6'h18 && !a[3]) begin
            if (w && !dn) lo[b ^ a[4]][a[2:0]] = d;
            v = lo[b ^ a[4]][a[2:0]];
        end else if (a < 6'h10) begin
            if (w) hi[a[2:0]] = d;
            v = hi[a[2:0]];
        end else if (!dn) begin
            m = (j == 2 || (j == 0 && p)) ? IM : (j == 0 ? IM & ~PM : 32'hFFFFFFFF);
            if (w) sys[j] = (sys[j] & ~m) | (d & m);
            v = (j == 0 && !p) ? sys[0] & ~PM : sys[j];
        end
        if (w || dn) v = 32'h0;
    endtask
    task automatic mEvt(input logic [1:0] k, input logic [31:0] off);
        if (k < 2'd2) begin
            sys[2] = sys[0];
            sys[3] = sys[8];
            sys[8] = sys[4] + off;
            sys[0] = sys[0] | `RF_STAT_ENTRY_SET;
        end else if (sys[0][30]) begin
            sys[8] = sys[3];
            sys[0] = sys[2];
        end
    endtask
    task automatic view();
        #1;
        `CHK(privMode, sys[0][30])
        `CHK(bankSelect, sys[0][29])
        `CHK(blockBit, sys[0][28])
        `CHK(interruptMaskLevel, sys[0][7:4])
        `CHK(indexValue, lo[sys[0][30] & sys[0][29]][0])
        `CHK(instructionPointer, sys[8])
        `CHK(vectorBase, sys[4])
    endtask
    task automatic op(input bit w, input logic [5:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic [31:0] ev;
        logic        dn;
        logic        edn;
        cpuModel.acc(w, a, d, v, dn);
        mAcc(w, a, d, ev, edn);
        `CHK(v, ev)
        `CHK(dn, edn)
        view();
    endtask
    task automatic ev(input logic [1:0] k, input logic [31:0] off);
        cpuModel.evt(k, off);
        mEvt(k, off);
        view();
    endtask
    task automatic do_reset(input int n);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (n) @(posedge clk);
        rstn <= 1'b1;
        sys = '{default: 32'h0};
        lo = '{default: 32'h0};
        hi = '{default: 32'h0};
        sys[0] = `RF_STAT_RESET;
        sys[8] = `RF_IPTR_RESET;
        view();
    endtask
    task automatic rnd(input int n);
        logic [31:0] r;
        logic [31:0] d;
        repeat (n) begin
            r = $random(seed);
            d = $random(seed);
            cpuModel.gap = r[14] ? int'(r[13:12]) : 0;
            if (r[10:8] == 3'd7)
                ev(r[11] ? 2'd2 : {1'b0, r[12]}, d);
            else if (r[10:8] == 3'd6)
                op(1'b1, `RF_ADDR_STATUS, d);
            else
                op(r[8], r[15] ? r[5:0] : {1'b0, r[4:0]}, d);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        do_reset(7);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            op(1'b1, 6'(i), 32'h100 + 32'(i));
            op(1'b1, 6'h10 + 6'(i), 32'h200 + 32'(i));
        end
        // Every mapped index plus one unmapped, in both privileged banks and in user mode with bank zero
        foreach (modes[k]) begin
            op(1'b1, `RF_ADDR_STATUS, modes[k]);
            for (int i = 0; i < 34; i++)
                op(1'b0, 6'(i), 32'h0);
        end
        ev(2'd2, 32'h0);
        ev(2'd0, 32'h40);
        op(1'b0, `RF_ADDR_SAVED_IP, 32'h0);
        op(1'b0, `RF_ADDR_SSTATUS, 32'h0);
        ev(2'd2, 32'h0);
        ev(2'd1, 32'h80);
        $display("test modes done");
        rnd(400);
        do_reset(2);
        rnd(400);
        $display("test random done");
        give_verdict();
    end
    initial begin
        #1000000;
        error_cnt++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire

// *** src/banked_cpu_register_file.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rf_params.svh"

module banked_cpu_register_file (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Register access port
    input  wire logic [`RF_ADDR_W-1:0] regAddr,
    input  wire logic [31:0]           regWdata,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic [31:0]                regRdata,
    output logic                       regDenied,
    // Exception sequencing
    input  wire logic                  excEvent,
    input  wire logic                  intAccept,
    input  wire logic [31:0]           excOffset,
    input  wire logic                  rteEvent,
    // Mode and status view
    output logic                       privMode,
    output logic                       bankSelect,
    output logic                       blockBit,
    output logic [3:0]                 interruptMaskLevel,
    output logic [31:0]                indexValue,
    output logic [31:0]                instructionPointer,
    output logic [31:0]                vectorBase
);

    rf_pkg::rf_state_t state_reg;
    rf_pkg::rf_state_t state_next;
    rf_pkg::decode_t   dec;
    rf_pkg::reg_req_t  req;

    // Privilege follows the mode bit alone
    function automatic logic isPrivileged(input rf_pkg::word_t sw);
        isPrivileged = sw[`RF_STAT_MODE];
    endfunction

    // Physical bank that serves general R0 to R7
    function automatic logic generalBank(input rf_pkg::word_t sw);
        generalBank = sw[`RF_STAT_MODE] & sw[`RF_STAT_BANK];
    endfunction

    // Status word as seen by the current mode
    function automatic rf_pkg::word_t statusView(input rf_pkg::word_t sw);
        if (isPrivileged(sw)) begin
            statusView = sw & `RF_STAT_IMPL_MASK;
        end else begin
            statusView = sw & `RF_STAT_IMPL_MASK & ~`RF_STAT_PRIV_MASK;
        end
    endfunction

    assign req.addr  = regAddr;
    assign req.wdata = regWdata;
    assign req.write = regWrite;
    assign req.read  = regRead;

    // Decode always uses the registered status word, so a status write
    // lands before the next access is decoded
    rf_access_decode u_decode (
        .addr       (req.addr),
        .privileged (isPrivileged(state_reg.statusWord)),
        .bankSelect (state_reg.statusWord[`RF_STAT_BANK]),
        .dec        (dec)
    );

    always_comb begin
        state_next        = state_reg;
        state_next.rdata  = `RF_READ_NONE;
        state_next.denied = 1'b0;

        // Write path
        if (req.write) begin
            if (!dec.allowed) begin
                state_next.denied = 1'b1;
            end else begin
                case (dec.kind)
                    rf_pkg::K_LOW: begin
                        state_next.lowRegs[dec.bank][dec.idx] = req.wdata;
                    end
                    rf_pkg::K_HIGH: begin
                        state_next.highRegs[dec.idx] = req.wdata;
                    end
                    rf_pkg::K_STATUS: begin
                        if (isPrivileged(state_reg.statusWord)) begin
                            state_next.statusWord = req.wdata & `RF_STAT_IMPL_MASK;
                        end else begin
                            // User writes leave guarded bits untouched
                            state_next.statusWord = (state_reg.statusWord & `RF_STAT_PRIV_MASK)
                                | (req.wdata & `RF_STAT_IMPL_MASK & ~`RF_STAT_PRIV_MASK);
                        end
                    end
                    rf_pkg::K_GLOBAL: begin
                        state_next.globalBase = req.wdata;
                    end
                    rf_pkg::K_SSTAT: begin
                        state_next.savedStatus = req.wdata & `RF_STAT_IMPL_MASK;
                    end
                    rf_pkg::K_SAVED_IP: begin
                        state_next.savedProgramCounter = req.wdata;
                    end
                    rf_pkg::K_VBASE: begin
                        state_next.vectorBase = req.wdata;
                    end
                    rf_pkg::K_MAC_HI: begin
                        state_next.macHigh = req.wdata;
                    end
                    rf_pkg::K_MAC_LO: begin
                        state_next.macLow = req.wdata;
                    end
                    rf_pkg::K_LINK: begin
                        state_next.returnLink = req.wdata;
                    end
                    rf_pkg::K_IPTR: begin
                        state_next.instructionPointer = req.wdata;
                    end
                    default: begin
                        state_next.denied = 1'b1;
                    end
                endcase
            end
        end

        // Read path, answered in the following cycle only
        if (req.read) begin
            if (!dec.allowed) begin
                state_next.denied = 1'b1;
            end else begin
                case (dec.kind)
                    rf_pkg::K_LOW: begin
                        state_next.rdata = state_reg.lowRegs[dec.bank][dec.idx];
                    end
                    rf_pkg::K_HIGH: begin
                        state_next.rdata = state_reg.highRegs[dec.idx];
                    end
                    rf_pkg::K_STATUS: begin
                        state_next.rdata = statusView(state_reg.statusWord);
                    end
                    rf_pkg::K_GLOBAL: begin
                        state_next.rdata = state_reg.globalBase;
                    end
                    rf_pkg::K_SSTAT: begin
                        state_next.rdata = state_reg.savedStatus;
                    end
                    rf_pkg::K_SAVED_IP: begin
                        state_next.rdata = state_reg.savedProgramCounter;
                    end
                    rf_pkg::K_VBASE: begin
                        state_next.rdata = state_reg.vectorBase;
                    end
                    rf_pkg::K_MAC_HI: begin
                        state_next.rdata = state_reg.macHigh;
                    end
                    rf_pkg::K_MAC_LO: begin
                        state_next.rdata = state_reg.macLow;
                    end
                    rf_pkg::K_LINK: begin
                        state_next.rdata = state_reg.returnLink;
                    end
                    rf_pkg::K_IPTR: begin
                        state_next.rdata = state_reg.instructionPointer;
                    end
                    default: begin
                        state_next.denied = 1'b1;
                    end
                endcase
            end
        end

        // Return from exception; ignored outside privileged mode
        if (rteEvent && isPrivileged(state_reg.statusWord)) begin
            state_next.instructionPointer = state_reg.savedProgramCounter;
            state_next.statusWord         = state_reg.savedStatus & `RF_STAT_IMPL_MASK;
        end

        // Exception entry overrides a same-cycle port write or return
        if (excEvent || intAccept) begin
            state_next.savedProgramCounter = state_reg.instructionPointer;
            state_next.savedStatus         = state_reg.statusWord;
            state_next.statusWord          = state_reg.statusWord | `RF_STAT_ENTRY_SET;
            state_next.instructionPointer  = state_reg.vectorBase + excOffset;
        end

        // Index register tracks the mapping that the next access will see
        state_next.indexValue = state_next.lowRegs[generalBank(state_next.statusWord)][0];
    end

    // One reset input serves both power-on and manual reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg                    <= '0;
            state_reg.statusWord         <= `RF_STAT_RESET;
            state_reg.vectorBase         <= `RF_VBASE_RESET;
            state_reg.instructionPointer <= `RF_IPTR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdata           = state_reg.rdata;
    assign regDenied          = state_reg.denied;
    assign privMode           = state_reg.statusWord[`RF_STAT_MODE];
    assign bankSelect         = state_reg.statusWord[`RF_STAT_BANK];
    assign blockBit           = state_reg.statusWord[`RF_STAT_BLOCK];
    assign interruptMaskLevel = state_reg.statusWord[`RF_STAT_IMASK_HI:`RF_STAT_IMASK_LO];
    assign indexValue         = state_reg.indexValue;
    assign instructionPointer = state_reg.instructionPointer;
    assign vectorBase         = state_reg.vectorBase;

endmodule // banked_cpu_register_file

`default_nettype wire

// *** src/rf_access_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rf_params.svh"

module rf_access_decode (
    // Access
    input  wire logic [`RF_ADDR_W-1:0] addr,
    // Current mode
    input  wire logic                  privileged,
    input  wire logic                  bankSelect,
    // Result
    output rf_pkg::decode_t            dec
);

    always_comb begin
        dec.kind    = rf_pkg::K_NONE;
        dec.bank    = 1'b0;
        dec.idx     = addr[2:0];
        dec.allowed = 1'b0;
        if (addr <= `RF_ADDR_GEN_HI) begin
            dec.allowed = 1'b1;
            if (!addr[3]) begin
                dec.kind = rf_pkg::K_LOW;
                // User mode always sees bank zero
                dec.bank = privileged & bankSelect;
            end else begin
                dec.kind = rf_pkg::K_HIGH;
            end
        end else if (addr[5:3] == `RF_ADDR_ALT_TAG) begin
            // The bank not mapped as general, control-insn path only
            dec.kind    = rf_pkg::K_LOW;
            dec.bank    = ~bankSelect;
            dec.allowed = privileged;
        end else begin
            case (addr)
                `RF_ADDR_STATUS: begin
                    dec.kind    = rf_pkg::K_STATUS;
                    dec.allowed = 1'b1;
                end
                `RF_ADDR_GLOBAL: begin
                    dec.kind    = rf_pkg::K_GLOBAL;
                    dec.allowed = 1'b1;
                end
                `RF_ADDR_SSTATUS: begin
                    dec.kind    = rf_pkg::K_SSTAT;
                    dec.allowed = privileged;
                end
                `RF_ADDR_SAVED_IP: begin
                    dec.kind    = rf_pkg::K_SAVED_IP;
                    dec.allowed = privileged;
                end
                `RF_ADDR_VBASE: begin
                    dec.kind    = rf_pkg::K_VBASE;
                    dec.allowed = privileged;
                end
                `RF_ADDR_MAC_HI: begin
                    dec.kind    = rf_pkg::K_MAC_HI;
                    dec.allowed = 1'b1;
                end
                `RF_ADDR_MAC_LO: begin
                    dec.kind    = rf_pkg::K_MAC_LO;
                    dec.allowed = 1'b1;
                end
                `RF_ADDR_LINK: begin
                    dec.kind    = rf_pkg::K_LINK;
                    dec.allowed = 1'b1;
                end
                `RF_ADDR_IPTR: begin
                    dec.kind    = rf_pkg::K_IPTR;
                    dec.allowed = 1'b1;
                end
                default: begin
                    dec.kind    = rf_pkg::K_NONE;
                    dec.allowed = 1'b0;
                end
            endcase
        end
    end

endmodule // rf_access_decode

`default_nettype wire

// *** src/rf_params.svh ***
`ifndef RF_PARAMS_SVH
`define RF_PARAMS_SVH

// Register port address map, 6-bit word index
`define RF_ADDR_W           6
`define RF_ADDR_GEN_HI      6'h0F
`define RF_ADDR_ALT_TAG     3'h2
`define RF_ADDR_STATUS      6'h18
`define RF_ADDR_GLOBAL      6'h19
`define RF_ADDR_SSTATUS     6'h1A
`define RF_ADDR_SAVED_IP    6'h1B
`define RF_ADDR_VBASE       6'h1C
`define RF_ADDR_MAC_HI      6'h1D
`define RF_ADDR_MAC_LO      6'h1E
`define RF_ADDR_LINK        6'h1F
`define RF_ADDR_IPTR        6'h20

// Status word field positions
`define RF_STAT_MODE        30
`define RF_STAT_BANK        29
`define RF_STAT_BLOCK       28
`define RF_STAT_IMASK_HI    7
`define RF_STAT_IMASK_LO    4

// Status word masks: implemented bits, privileged-only bits
`define RF_STAT_IMPL_MASK   32'h700003F3
`define RF_STAT_PRIV_MASK   32'h700000F0
`define RF_STAT_ENTRY_SET   32'h70000000

// Reset values
`define RF_STAT_RESET       32'h700000F0
`define RF_VBASE_RESET      32'h00000000
`define RF_IPTR_RESET       32'hA0000000
`define RF_READ_NONE        32'h00000000

`endif

// *** src/rf_pkg.sv ***
`include "rf_params.svh"

package rf_pkg;

    typedef logic [31:0] word_t;

    // Target of one register-port access, one-hot
    typedef enum logic [10:0] {
        K_NONE   = 11'h000,
        K_LOW    = 11'h001,
        K_HIGH   = 11'h002,
        K_STATUS = 11'h004,
        K_GLOBAL = 11'h008,
        K_SSTAT  = 11'h010,
        K_SAVED_IP = 11'h020,
        K_VBASE  = 11'h040,
        K_MAC_HI = 11'h080,
        K_MAC_LO = 11'h100,
        K_LINK   = 11'h200,
        K_IPTR   = 11'h400
    } access_kind_t;

    typedef struct packed {
        access_kind_t kind;
        logic         bank;
        logic [2:0]   idx;
        logic         allowed;
    } decode_t;

    typedef struct packed {
        logic [`RF_ADDR_W-1:0] addr;
        word_t                 wdata;
        logic                  write;
        logic                  read;
    } reg_req_t;

    typedef struct packed {
        word_t                  statusWord;
        word_t                  globalBase;
        word_t                  savedStatus;
        word_t                  savedProgramCounter;
        word_t                  vectorBase;
        word_t                  macHigh;
        word_t                  macLow;
        word_t                  returnLink;
        word_t                  instructionPointer;
        logic [1:0][7:0][31:0]  lowRegs;
        logic [7:0][31:0]       highRegs;
        word_t                  rdata;
        logic                   denied;
        word_t                  indexValue;
    } rf_state_t;

endpackage
